// ---- common/ltc_pkg.sv ----
// Constants and types for the link transaction control register block.
package ltc_pkg;

    // Configuration space location of the control register.
    localparam logic [2:0]  LTC_CFG_FUNC   = 3'h0;
    localparam logic [7:0]  LTC_CFG_OFFSET = 8'h68;
    localparam logic [31:0] LTC_RESET      = 32'h0F00_0000;

    // Field positions.
    localparam int B_NO_PROBE_BYTE_READ   = 0;
    localparam int B_NO_PROBE_DWORD_READ  = 1;
    localparam int B_NO_PROBE_BYTE_WRITE  = 2;
    localparam int B_NO_PROBE_DWORD_WRITE = 3;
    localparam int B_TARGET_START_OFF     = 4;
    localparam int B_SECOND_CORE_ENABLE   = 5;
    localparam int B_CORE_REQ_PASS        = 6;
    localparam int B_CORE_RD_RESP_PASS    = 7;
    localparam int B_PROBE_CANCEL_OFF     = 8;
    localparam int B_REMOTE_CANCEL_OFF    = 9;
    localparam int B_FILL_PROBE_OFF       = 10;
    localparam int B_DS_RESP_PASS         = 11;
    localparam int B_ISOC_AS_ORDERED      = 12;
    localparam int B_BUF_REL_LO           = 13;
    localparam int B_LIMIT_COH_CFG        = 15;
    localparam int B_DS_NP_CAP_LO         = 21;
    localparam int B_HP_BYPASS_LO         = 26;
    localparam int B_ISOC_HI_OFF          = 30;
    localparam int B_ISOC_MED_OFF         = 31;

    // Buffer release thresholds in link doublewords.
    localparam logic [6:0] LTC_BRT_SEL0 = 7'h40;
    localparam logic [6:0] LTC_BRT_SEL1 = 7'h10;
    localparam logic [6:0] LTC_BRT_SEL2 = 7'h08;
    localparam logic [6:0] LTC_BRT_SEL3 = 7'h02;

    // Outstanding downstream non-posted caps; zero means unlimited.
    localparam logic [3:0] LTC_NP_SEL0 = 4'h0;
    localparam logic [3:0] LTC_NP_SEL1 = 4'h1;
    localparam logic [3:0] LTC_NP_SEL2 = 4'h4;
    localparam logic [3:0] LTC_NP_SEL3 = 4'h8;

    typedef enum logic [2:0] {
        KIND_BYTE_READ,
        KIND_DWORD_READ,
        KIND_BYTE_WRITE,
        KIND_DWORD_WRITE,
        KIND_FILL,
        KIND_OTHER
    } ltc_kind_t;

    typedef enum logic [1:0] {
        PRIO_LOW,
        PRIO_MED,
        PRIO_HIGH
    } ltc_prio_t;

endpackage

// ---- hdl/ltc_event_cnt.sv ----
// Saturating event counter that flags when a programmed limit is reached.
`timescale 1ns/1ps
module ltc_event_cnt
    import ltc_pkg::*;
#(
    parameter int W = 7
)
(
    input  wire logic         clk,      // System clock.
    input  wire logic         reset_n,  // Synchronous reset, active low.
    input  wire logic         clear,    // Restart the count.
    input  wire logic         step,     // One event to count.
    input  wire logic [W-1:0] limit,    // Count at which reached rises.
    output logic              reached   // Count has met the limit.
);

    logic [W-1:0] cnt_q;

    // Clear wins over step so a restart never carries a stale event.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            cnt_q <= '0;
        else if (clear)
            cnt_q <= '0;
        else if (step && (cnt_q != '1))
            cnt_q <= cnt_q + W'(1);
    end

    assign reached = (cnt_q >= limit);

endmodule

// ---- hdl/ltc_transaction_ctrl.sv ----
// Link transaction control register and the per-transaction decisions it steers.
`timescale 1ns/1ps
module ltc_transaction_ctrl
    import ltc_pkg::*;
(
    input  wire logic        clk,                 // System clock, 125 MHz.
    input  wire logic        reset_n,             // Synchronous reset, active low.
    // Configuration access port.
    input  wire logic        cfg_valid,           // Access request, one cycle.
    input  wire logic        cfg_write,           // 1 write, 0 read.
    input  wire logic [2:0]  cfg_func,            // Configuration function number.
    input  wire logic [7:0]  cfg_offset,          // Byte offset of the register.
    input  wire logic [3:0]  cfg_be,              // Byte enables for writes.
    input  wire logic [31:0] cfg_wdata,           // Write data.
    output logic             cfg_ack,             // Access claimed, one cycle later.
    output logic [31:0]      cfg_rdata,           // Read data, valid with ack.
    // Core request classification.
    input  wire logic        req_valid,           // Core request issued.
    input  wire ltc_kind_t   req_kind,            // Size class of the request.
    input  wire logic        req_cmd_bit1,        // Bit 1 of the sized command.
    input  wire logic        req_is_write,        // Request is a write.
    output logic             dec_valid,           // Decision for the request.
    output logic             dec_probe,           // Issue probes for it.
    output logic             dec_pass_posted,     // May pass posted writes.
    output logic             dec_ordered,         // Command bit 1 means ordered.
    output ltc_prio_t        dec_prio,            // Isochronous write priority.
    // Target start at the memory controller.
    input  wire logic        mc_ordered,          // Ordered transaction received.
    output logic             tgt_start,           // Send target-start packet.
    // Read responses to core reads.
    input  wire logic        rrsp_valid,          // Read response to a core read.
    output logic             rrsp_valid_o,        // Decision valid.
    output logic             rrsp_pass_posted,    // Response may pass posted writes.
    // Probe dirty hits.
    input  wire logic        dirty_hit,           // Probe hit a dirty block.
    input  wire logic        dirty_hit_local,     // Cache is on the memory's node.
    output logic             mem_cancel,          // Send a memory cancel.
    // Downstream responses in the host bridge.
    input  wire logic        dsr_valid,           // Downstream response.
    input  wire logic        dsr_req_pass,        // Pass flag of the original request.
    output logic             dsr_valid_o,         // Decision valid.
    output logic             dsr_pass_posted,     // Pass flag to send.
    // Configuration routing.
    input  wire logic        cra_valid,           // Config access to coherent space.
    input  wire logic [2:0]  cra_node,            // Target node.
    input  wire logic [2:0]  node_count,          // Node count minus one.
    output logic             cra_valid_o,         // Decision valid.
    output logic             cra_noncoherent,     // Redirect to noncoherent link.
    // Downstream non-posted limiter.
    input  wire logic        np_issue,            // Non-posted request sent.
    input  wire logic        np_done,             // Non-posted request completed.
    output logic             np_stall,            // Hold further non-posted requests.
    // Buffer release insertion.
    input  wire logic        rel_pending,         // Buffer release waiting.
    input  wire logic        link_dw_sent,        // One link doubleword sent.
    input  wire logic        link_busy,           // Link stream is busy.
    input  wire logic        rel_sent,            // Release went out.
    output logic             rel_force,           // Force release into the stream.
    // High-priority bypass control.
    input  wire logic        hp_bypass,           // High access passed a lower one.
    input  wire logic        acc_done,            // An access was serviced.
    output logic             hp_suspend,          // High priority mode held off.
    // Core enable.
    output logic             second_core_enable   // Second core may fetch.
);

    ////////////////////////////////////////////////////////////////////////////
    // Control register.

    logic [31:0] ctrl_q;
    logic        cfg_hit;

    assign cfg_hit = cfg_valid && (cfg_func == LTC_CFG_FUNC) && (cfg_offset == LTC_CFG_OFFSET);

    // Per-byte write; every bit is read/write so nothing is masked.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            ctrl_q <= LTC_RESET;
        else if (cfg_hit && cfg_write)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (cfg_be[i])
                    ctrl_q[8*i +: 8] <= cfg_wdata[8*i +: 8];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= '0;
        end
        else
        begin
            cfg_ack   <= cfg_hit;
            cfg_rdata <= (cfg_hit && !cfg_write) ? ctrl_q : '0;
        end
    end

    // A transaction in the same cycle as a write still samples the old
    // value, since every decision below reads ctrl_q before it updates.
    assign second_core_enable = ctrl_q[B_SECOND_CORE_ENABLE];

    ////////////////////////////////////////////////////////////////////////////
    // Core request decisions, latched once at issue.

    logic probe_d;
    logic prio_hi_off;
    logic prio_med_off;

    always_comb
    begin
        case (req_kind)
            KIND_BYTE_READ:   probe_d = !ctrl_q[B_NO_PROBE_BYTE_READ];
            KIND_DWORD_READ:  probe_d = !ctrl_q[B_NO_PROBE_DWORD_READ];
            KIND_BYTE_WRITE:  probe_d = !ctrl_q[B_NO_PROBE_BYTE_WRITE];
            KIND_DWORD_WRITE: probe_d = !ctrl_q[B_NO_PROBE_DWORD_WRITE];
            KIND_FILL:        probe_d = !ctrl_q[B_FILL_PROBE_OFF];
            default:          probe_d = 1'b1;
        endcase
    end

    assign prio_hi_off  = ctrl_q[B_ISOC_HI_OFF];
    assign prio_med_off = ctrl_q[B_ISOC_MED_OFF];

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            dec_valid       <= 1'b0;
            dec_probe       <= 1'b0;
            dec_pass_posted <= 1'b0;
            dec_ordered     <= 1'b0;
            dec_prio        <= PRIO_LOW;
        end
        else
        begin
            dec_valid <= req_valid;
            if (req_valid)
            begin
                dec_probe       <= probe_d;
                dec_pass_posted <= ctrl_q[B_CORE_REQ_PASS];
                dec_ordered     <= ctrl_q[B_ISOC_AS_ORDERED] && req_cmd_bit1;
                // Priority only applies to isochronous writes while bit 1
                // still means isochronous.
                if (!req_is_write || !req_cmd_bit1 || ctrl_q[B_ISOC_AS_ORDERED])
                    dec_prio <= PRIO_LOW;
                else if (!prio_hi_off)
                    dec_prio <= PRIO_HIGH;
                else if (prio_med_off)
                    dec_prio <= PRIO_LOW;
                else
                    dec_prio <= PRIO_MED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory controller, probe and response decisions.

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            tgt_start  <= 1'b0;
            mem_cancel <= 1'b0;
        end
        else
        begin
            tgt_start  <= mc_ordered && !ctrl_q[B_TARGET_START_OFF];
            mem_cancel <= dirty_hit && !ctrl_q[B_PROBE_CANCEL_OFF]
                          && (dirty_hit_local || !ctrl_q[B_REMOTE_CANCEL_OFF]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rrsp_valid_o     <= 1'b0;
            rrsp_pass_posted <= 1'b0;
            dsr_valid_o      <= 1'b0;
            dsr_pass_posted  <= 1'b0;
        end
        else
        begin
            rrsp_valid_o <= rrsp_valid;
            dsr_valid_o  <= dsr_valid;
            if (rrsp_valid)
                rrsp_pass_posted <= ctrl_q[B_CORE_RD_RESP_PASS];
            if (dsr_valid)
                dsr_pass_posted <= ctrl_q[B_DS_RESP_PASS] || dsr_req_pass;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration routing to absent nodes.

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cra_valid_o     <= 1'b0;
            cra_noncoherent <= 1'b0;
        end
        else
        begin
            cra_valid_o <= cra_valid;
            if (cra_valid)
                cra_noncoherent <= ctrl_q[B_LIMIT_COH_CFG] && (cra_node > node_count);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Downstream non-posted limiter.

    logic [3:0] np_cap;
    logic [3:0] np_out_q;

    always_comb
    begin
        case (ctrl_q[B_DS_NP_CAP_LO +: 2])
            2'h1:    np_cap = LTC_NP_SEL1;
            2'h2:    np_cap = LTC_NP_SEL2;
            2'h3:    np_cap = LTC_NP_SEL3;
            default: np_cap = LTC_NP_SEL0;
        endcase
    end

    // Lowering the cap below the outstanding count only stalls new issues;
    // requests already out drain normally.
    assign np_stall = (np_cap != LTC_NP_SEL0) && (np_out_q >= np_cap);

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            np_out_q <= '0;
        else
        begin
            case ({np_issue && (np_out_q != 4'hF), np_done && (np_out_q != 4'h0)})
                2'b10:   np_out_q <= np_out_q + 4'h1;
                2'b01:   np_out_q <= np_out_q - 4'h1;
                default: np_out_q <= np_out_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffer release insertion threshold.

    logic [6:0] rel_limit;
    logic       rel_reached;

    always_comb
    begin
        case (ctrl_q[B_BUF_REL_LO +: 2])
            2'h1:    rel_limit = LTC_BRT_SEL1;
            2'h2:    rel_limit = LTC_BRT_SEL2;
            2'h3:    rel_limit = LTC_BRT_SEL3;
            default: rel_limit = LTC_BRT_SEL0;
        endcase
    end

    ltc_event_cnt #(.W(7)) u_rel_cnt
    (
        .clk     (clk),
        .reset_n (reset_n),
        .clear   (rel_sent || !rel_pending),
        .step    (rel_pending && link_dw_sent),
        .limit   (rel_limit),
        .reached (rel_reached)
    );

    assign rel_force = rel_pending && link_busy && rel_reached;

    ////////////////////////////////////////////////////////////////////////////
    // High-priority bypass limit.

    logic hp_reached;
    logic hp_hold_q;

    ltc_event_cnt #(.W(2)) u_hp_cnt
    (
        .clk     (clk),
        .reset_n (reset_n),
        .clear   (hp_hold_q && acc_done),
        .step    (hp_bypass && !hp_suspend),
        .limit   (ctrl_q[B_HP_BYPASS_LO +: 2]),
        .reached (hp_reached)
    );

    // Once a nonzero count is spent, high priority sits out exactly one access.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            hp_hold_q <= 1'b0;
        else if (hp_hold_q && acc_done)
            hp_hold_q <= 1'b0;
        else if (hp_reached)
            hp_hold_q <= 1'b1;
    end

    assign hp_suspend = hp_hold_q || hp_reached;

endmodule

// ---- test/ltc_transaction_ctrl_assertions.sv ----
// Port-level concurrent checks for the link transaction control block.
`timescale 1ns/1ps
module ltc_chk
    import ltc_pkg::*;
(
    input wire logic        clk,                // Clock.
    input wire logic        reset_n,            // Reset, active low.
    input wire logic        cfg_valid,          // Config request.
    input wire logic        cfg_write,          // Write strobe.
    input wire logic [2:0]  cfg_func,           // Function.
    input wire logic [7:0]  cfg_offset,         // Offset.
    input wire logic [3:0]  cfg_be,             // Byte enables.
    input wire logic [31:0] cfg_wdata,          // Write data.
    input wire logic        cfg_ack,            // Claim.
    input wire logic [31:0] cfg_rdata,          // Read data.
    input wire logic        req_valid,          // Core request.
    input wire ltc_kind_t   req_kind,           // Request kind.
    input wire logic        req_cmd_bit1,       // Command bit 1.
    input wire logic        dec_valid,          // Decision valid.
    input wire logic        dec_probe,          // Probe decision.
    input wire logic        dec_ordered,        // Ordered decision.
    input wire logic        mc_ordered,         // Ordered arrival.
    input wire logic        tgt_start,          // Target start.
    input wire logic        dirty_hit,          // Dirty probe hit.
    input wire logic        dirty_hit_local,    // Hit is local.
    input wire logic        mem_cancel,         // Memory cancel.
    input wire logic        second_core_enable  // Core enable.
);
    logic [31:0] reg_q;
    logic [31:0] reg_d;
    logic        probe_exp;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence hit_s;
        cfg_valid && cfg_func == LTC_CFG_FUNC && cfg_offset == LTC_CFG_OFFSET;
    endsequence

    sequence read_s;
        hit_s ##0 !cfg_write;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the register, merged byte by byte as the enables select.
    always_comb
    begin
        reg_d = reg_q;
        for (int i = 0; i < 4; i++)
            if (cfg_be[i]) reg_d[8*i +: 8] = cfg_wdata[8*i +: 8];
    end

    always_ff @(posedge clk)
        if (!reset_n) reg_q <= LTC_RESET;
        else if (cfg_valid && cfg_write && cfg_func == LTC_CFG_FUNC
                 && cfg_offset == LTC_CFG_OFFSET) reg_q <= reg_d;

    always_comb
        case (req_kind)
            KIND_BYTE_READ:   probe_exp = !reg_q[B_NO_PROBE_BYTE_READ];
            KIND_DWORD_READ:  probe_exp = !reg_q[B_NO_PROBE_DWORD_READ];
            KIND_BYTE_WRITE:  probe_exp = !reg_q[B_NO_PROBE_BYTE_WRITE];
            KIND_DWORD_WRITE: probe_exp = !reg_q[B_NO_PROBE_DWORD_WRITE];
            KIND_FILL:        probe_exp = !reg_q[B_FILL_PROBE_OFF];
            default:          probe_exp = 1'b1;
        endcase

    ////////////////////////////////////////////////////////////////////////////////
    cfg_ack_a: assert property (hit_s |=> cfg_ack)
        else $error("config access not acknowledged");
    no_ack_a: assert property (!(cfg_valid && cfg_func == LTC_CFG_FUNC
        && cfg_offset == LTC_CFG_OFFSET) |=> !cfg_ack) else $error("stray ack");
    read_data_a: assert property (read_s |=> cfg_ack && cfg_rdata == $past(reg_q))
        else $error("read data differs from register");
    core_enable_a: assert property (second_core_enable == reg_q[B_SECOND_CORE_ENABLE])
        else $error("second core enable differs from bit 5");
    probe_sel_a: assert property (req_valid |=> dec_valid
        && dec_probe == $past(probe_exp)) else $error("probe decision wrong");
    ordered_flag_a: assert property (req_valid |=> dec_ordered ==
        ($past(reg_q[B_ISOC_AS_ORDERED]) && $past(req_cmd_bit1)))
        else $error("ordered flag wrong");
    target_start_a: assert property (mc_ordered |=>
        tgt_start == !$past(reg_q[B_TARGET_START_OFF])) else $error("target start wrong");
    mem_cancel_a: assert property (dirty_hit |=> mem_cancel ==
        (!$past(reg_q[B_PROBE_CANCEL_OFF]) && ($past(dirty_hit_local)
        || !$past(reg_q[B_REMOTE_CANCEL_OFF])))) else $error("cancel wrong");
endmodule

bind ltc_transaction_ctrl ltc_chk u_chk (.clk, .reset_n, .cfg_valid, .cfg_write, .cfg_func,
    .cfg_offset, .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata, .req_valid, .req_kind, .req_cmd_bit1,
    .dec_valid, .dec_probe, .dec_ordered, .mc_ordered, .tgt_start, .dirty_hit, .dirty_hit_local,
    .mem_cancel, .second_core_enable);

// ---- test/tb.sv ----
// Self-checking testbench for the link transaction control block.
`timescale 1ns/1ps
module tb;
    import ltc_pkg::*;
    logic        clk, reset_n, cfg_valid, cfg_write, cfg_ack;
    logic [2:0]  cfg_func, cra_node, node_count;
    logic [7:0]  cfg_offset;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic        req_valid, req_cmd_bit1, req_is_write, dec_valid, dec_probe, dec_pass_posted;
    logic        dec_ordered, mc_ordered, tgt_start, rrsp_valid, rrsp_valid_o, rrsp_pass_posted;
    logic        dirty_hit, dirty_hit_local, mem_cancel, dsr_valid, dsr_req_pass, dsr_valid_o;
    logic        dsr_pass_posted, cra_valid, cra_valid_o, cra_noncoherent, np_issue, np_done;
    logic        np_stall, rel_pending, link_dw_sent, link_busy, rel_sent, rel_force;
    logic        hp_bypass, acc_done, hp_suspend, second_core_enable;
    ltc_kind_t   req_kind;
    ltc_prio_t   dec_prio;
    int          err_count, checked, cycles;

    ltc_transaction_ctrl dut (.clk, .reset_n, .cfg_valid, .cfg_write, .cfg_func, .cfg_offset,
        .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata, .req_valid, .req_kind, .req_cmd_bit1,
        .req_is_write, .dec_valid, .dec_probe, .dec_pass_posted, .dec_ordered, .dec_prio,
        .mc_ordered, .tgt_start, .rrsp_valid, .rrsp_valid_o, .rrsp_pass_posted, .dirty_hit,
        .dirty_hit_local, .mem_cancel, .dsr_valid, .dsr_req_pass, .dsr_valid_o, .dsr_pass_posted,
        .cra_valid, .cra_node, .node_count, .cra_valid_o, .cra_noncoherent, .np_issue, .np_done,
        .np_stall, .rel_pending, .link_dw_sent, .link_busy, .rel_sent, .rel_force, .hp_bypass,
        .acc_done, .hp_suspend, .second_core_enable);

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // A hang is cut short well beyond the six hundred or so cycles the tests need.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task report_and_stop;
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task tick; @(posedge clk); #1; endtask

    // The leading edge keeps two pulses of one signal out of a single time step.
    task automatic pulse(ref logic s); tick; s = 1'b1; tick; s = 1'b0; endtask

    task cfg(input logic w, input logic [2:0] f, input logic [7:0] o, input logic [3:0] be,
             input logic [31:0] d, input logic ack, input logic [31:0] rd);
        tick;
        {cfg_valid, cfg_write, cfg_func, cfg_offset, cfg_be, cfg_wdata} = {1'b1, w, f, o, be, d};
        tick;
        cfg_valid = 1'b0;
        chk("cfg_ack", cfg_ack, ack);
        chk("cfg_rdata", cfg_rdata, rd);
    endtask

    task wr(input logic [31:0] d); cfg(1, 0, 8'h68, 4'hF, d, 1, 0); endtask
    task rd(input logic [31:0] e); cfg(0, 0, 8'h68, 4'h0, 0, 1, e); endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rd(LTC_RESET);
        chk("core_en", second_core_enable, 0);
        wr(32'hFFFF_FFFF);
        rd(32'hFFFF_FFFF);
        chk("core_en", second_core_enable, 1);
        cfg(1, 0, 8'h68, 4'h5, 32'h0, 1, 0);
        cfg(1, 3'h1, 8'h68, 4'hF, 32'h0, 0, 0);
        cfg(1, 0, 8'h6C, 4'hF, 32'h0, 0, 0);
        cfg(0, 0, 8'h64, 4'h0, 32'h0, 0, 0);
        rd(32'hFF00_FF00);
    endtask

    task t_probe;
        ltc_kind_t k[5];
        int        b[5];
        k = '{KIND_BYTE_READ, KIND_DWORD_READ, KIND_BYTE_WRITE, KIND_DWORD_WRITE, KIND_FILL};
        b = '{0, 1, 2, 3, 10};
        for (int i = 0; i < 10; i++)
        begin
            wr(i[0] ? 32'h1 << b[i/2] : ~(32'h1 << b[i/2]));
            req_kind = k[i/2];
            pulse(req_valid);
            chk("dec_valid", dec_valid, 1);
            chk("dec_probe", dec_probe, !i[0]);
            chk("dec_pass", dec_pass_posted, !i[0]);
        end
        wr(32'h0000_0010);
        chk("dec_probe", dec_probe, 0);
        req_kind = KIND_OTHER;
        pulse(req_valid);
        chk("dec_probe", dec_probe, 1);
    endtask

    task t_prio;
        ltc_prio_t p;
        req_kind = KIND_DWORD_WRITE;
        {req_is_write, req_cmd_bit1} = 2'b11;
        for (int j = 0; j < 8; j++)
        begin
            wr({j[2], j[1], 17'h0, j[0], 12'h0});
            p = j[0] ? PRIO_LOW : (!j[1] ? PRIO_HIGH : (j[2] ? PRIO_LOW : PRIO_MED));
            pulse(req_valid);
            chk("dec_prio", dec_prio, p);
            chk("dec_ordered", dec_ordered, j[0]);
        end
    endtask

    task t_misc;
        for (int j = 0; j < 16; j++)
        begin
            wr({16'h0, j[1], 3'h0, j[0] ^ j[3], 1'b0, j[3], j[2], j[1], 2'b0, j[0], 4'h0});
            pulse(mc_ordered);
            chk("tgt_start", tgt_start, !j[0]);
            pulse(rrsp_valid);
            chk("rrsp_pass", rrsp_pass_posted, j[1]);
            chk("rrsp_valid_o", rrsp_valid_o, 1);
            dsr_req_pass = j[2];
            pulse(dsr_valid);
            chk("dsr_pass", dsr_pass_posted, (j[0] ^ j[3]) | j[2]);
            chk("dsr_valid_o", dsr_valid_o, 1);
            {cra_node, node_count} = {3'h3, j[2] ? 3'h2 : 3'h3};
            pulse(cra_valid);
            chk("cra_nc", cra_noncoherent, j[1] & j[2]);
            chk("cra_valid_o", cra_valid_o, 1);
            dirty_hit_local = j[0];
            pulse(dirty_hit);
            chk("mem_cancel", mem_cancel, !j[2] & (j[0] | !j[3]));
        end
    endtask

    task t_np;
        int cap[4];
        cap = '{9, 1, 4, 8};
        for (int s = 0; s < 4; s++)
        begin
            wr(s << 21);
            repeat (cap[s] - 1) pulse(np_issue);
            chk("np_stall", np_stall, 0);
            pulse(np_issue);
            chk("np_stall", np_stall, s != 0);
            repeat (cap[s]) pulse(np_done);
            chk("np_stall", np_stall, 0);
        end
    endtask

    task t_rel;
        int thr[4];
        thr = '{64, 16, 8, 2};
        {rel_pending, link_busy} = 2'b11;
        for (int s = 0; s < 4; s++)
        begin
            wr(s << 13);
            repeat (thr[s] - 1) pulse(link_dw_sent);
            chk("rel_force", rel_force, 0);
            pulse(link_dw_sent);
            chk("rel_force", rel_force, 1);
            pulse(rel_sent);
            chk("rel_force", rel_force, 0);
        end
    endtask

    task t_hp;
        wr(32'h0800_0000);
        // Earlier scenarios left a zero count in place, so a hold is still
        // pending; one serviced access releases it before counting starts.
        pulse(acc_done);
        chk("hp_suspend", hp_suspend, 0);
        pulse(hp_bypass);
        chk("hp_suspend", hp_suspend, 0);
        pulse(hp_bypass);
        chk("hp_suspend", hp_suspend, 1);
        pulse(acc_done);
        tick;
        chk("hp_suspend", hp_suspend, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {cfg_valid, cfg_write, cfg_func, cfg_offset, cfg_be, cfg_wdata, req_valid} = '0;
        {req_cmd_bit1, req_is_write, mc_ordered, rrsp_valid, dirty_hit, dirty_hit_local} = '0;
        {dsr_valid, dsr_req_pass, cra_valid, cra_node, node_count, np_issue, np_done} = '0;
        {rel_pending, link_dw_sent, link_busy, rel_sent, hp_bypass, acc_done} = '0;
        req_kind = KIND_OTHER;
        reset_n = 1'b0;
        repeat (8) @(posedge clk);
        #1 reset_n = 1'b1;
        t_regs();
        t_probe();
        t_prio();
        t_misc();
        t_np();
        t_rel();
        t_hp();
        report_and_stop();
    end
endmodule
